// ==== src/pin_io_bank.sv ====
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
// register bank for port pin levels, open drain and clock gating
module pin_io_bank
  import pin_io_pkg::*;
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_b,
  // register port
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [DATA_W-1:0] regRdata,
  // pins
  input  wire logic [PIN_N-1:0]  pinIn,
  output logic      [PIN_N-1:0]  pinOut,
  output logic      [PIN_N-1:0]  pinOe,
  // clock gates
  output logic                   pinClockEn,
  output logic                   engineClockEn
);
  logic [PIN_N-1:0] outLevel_reg;
  logic [PIN_N-1:0] outLevel_next;
  logic [PIN_N-1:0] openDrain_reg;
  logic [PIN_N-1:0] openDrain_next;
  logic [1:0]       clkState_reg;
  logic [1:0]       clkState_next;
  logic [PIN_N-1:0] pinSample;
  logic [PIN_N-1:0] pinDriveReq;
  logic [DATA_W-1:0] rdMux;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    return a == off;
  endfunction : hit

  function automatic logic [DATA_W-1:0] placePins(input logic [PIN_N-1:0] p);
    logic [DATA_W-1:0] w;
    w = '0;
    w[PIN_MSB:PIN_LSB] = p;
    return w;
  endfunction : placePins

  wire logic [PIN_N-1:0] wPins = regWdata[PIN_MSB:PIN_LSB];
  wire logic [1:0] wClk = regWdata[CLK_ENG_BIT:CLK_PIN_BIT];
  wire logic wrSet   = regWr && hit(regAddr, SET_OUTPUT_LEVEL_OFF);
  wire logic wrClr   = regWr && hit(regAddr, CLEAR_OUTPUT_LEVEL_OFF);
  wire logic wrOdEn  = regWr && hit(regAddr, OPEN_DRAIN_ENABLE_OFF);
  wire logic wrOdDis = regWr && hit(regAddr, OPEN_DRAIN_DISABLE_OFF);
  wire logic wrCkEn  = regWr && hit(regAddr, CLOCK_ENABLE_OFF);
  wire logic wrCkDis = regWr && hit(regAddr, CLOCK_DISABLE_OFF);
  wire logic softRst = regWr && hit(regAddr, SOFT_RESET_OFF) && regWdata[SOFT_RESET_BIT];

  // a zero bit leaves the setting alone
  assign outLevel_next = softRst ? OUT_LEVEL_RST :
    ((outLevel_reg | (wrSet ? wPins : '0)) & ~(wrClr ? wPins : '0));
  assign openDrain_next = softRst ? OPEN_DRAIN_RST :
    ((openDrain_reg | (wrOdEn ? wPins : '0)) & ~(wrOdDis ? wPins : '0));
  // soft reset does not touch clock state
  assign clkState_next = (clkState_reg | (wrCkEn ? wClk : '0))
    & ~(wrCkDis ? wClk : '0);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      outLevel_reg  <= OUT_LEVEL_RST;
      openDrain_reg <= OPEN_DRAIN_RST;
      clkState_reg  <= CLK_STATE_RST;
    end else begin
      outLevel_reg  <= outLevel_next;
      openDrain_reg <= openDrain_next;
      clkState_reg  <= clkState_next;
    end
  end

  pin_sample u_pin_sample (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .pinIn     (pinIn),
    .pinSample (pinSample)
  );

  // open drain pins only ever pull low
  assign pinDriveReq = ~openDrain_reg | ~outLevel_reg;
  assign pinOut      = outLevel_reg;
  assign pinOe       = pinDriveReq;
  assign pinClockEn    = clkState_reg[CLK_PIN_BIT];
  assign engineClockEn = clkState_reg[CLK_ENG_BIT];

  assign rdMux =
    hit(regAddr, OUTPUT_LEVEL_STATUS_OFF) ? placePins(outLevel_reg) :
    hit(regAddr, PIN_LEVEL_STATUS_OFF)    ? placePins(pinSample) :
    hit(regAddr, OPEN_DRAIN_STATUS_OFF)   ? placePins(openDrain_reg) :
    hit(regAddr, POWER_CLOCK_STATUS_OFF)  ? {30'h0, clkState_reg} :
    '0;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      regRdata <= '0;
    end else begin
      regRdata <= regRd ? rdMux : '0;
    end
  end
endmodule : pin_io_bank

// ==== common/pin_io_pkg.sv ====
// register map, field layout and reset values of the port pin bank
package pin_io_pkg;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned PIN_N    = 7;
  localparam int unsigned PIN_LSB  = 16;
  localparam int unsigned PIN_MSB  = 22;
  // pin positions within the pin field
  localparam int unsigned PIN_CLK  = 0;
  localparam int unsigned PIN_DIN  = 1;
  localparam int unsigned PIN_DOUT = 2;
  localparam int unsigned PIN_CS0  = 3;
  // clock bits
  localparam int unsigned CLK_PIN_BIT = 0;
  localparam int unsigned CLK_ENG_BIT = 1;
  // offsets
  localparam logic [7:0] SET_OUTPUT_LEVEL_OFF    = 8'h30;
  localparam logic [7:0] CLEAR_OUTPUT_LEVEL_OFF  = 8'h34;
  localparam logic [7:0] OUTPUT_LEVEL_STATUS_OFF = 8'h38;
  localparam logic [7:0] PIN_LEVEL_STATUS_OFF    = 8'h3C;
  localparam logic [7:0] OPEN_DRAIN_ENABLE_OFF   = 8'h40;
  localparam logic [7:0] OPEN_DRAIN_DISABLE_OFF  = 8'h44;
  localparam logic [7:0] OPEN_DRAIN_STATUS_OFF   = 8'h48;
  localparam logic [7:0] CLOCK_ENABLE_OFF        = 8'h50;
  localparam logic [7:0] CLOCK_DISABLE_OFF       = 8'h54;
  localparam logic [7:0] POWER_CLOCK_STATUS_OFF  = 8'h58;
  localparam logic [7:0] SOFT_RESET_OFF          = 8'h60;
  localparam int unsigned SOFT_RESET_BIT         = 0;
  // reset values
  localparam logic [6:0] OUT_LEVEL_RST  = 7'h00;
  localparam logic [6:0] OPEN_DRAIN_RST = 7'h00;
  localparam logic [1:0] CLK_STATE_RST  = 2'h0;
endpackage : pin_io_pkg

// ==== src/pin_sample.sv ====
`timescale 1ns/1ps
// registered sample of the live pin levels
module pin_sample
  import pin_io_pkg::*;
(
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_b,
  // pins
  input  wire logic [PIN_N-1:0] pinIn,
  output logic      [PIN_N-1:0] pinSample
);
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pinSample <= '0;
    end else begin
      pinSample <= pinIn;
    end
  end
endmodule : pin_sample

// ==== tb/pin_io_bank_properties.sv ====
// assertions on the pin bank ports
`timescale 1ns/1ps
module pin_io_bank_properties (
  input wire logic        mclk, rst_b, regWr, regRd, pinClockEn, engineClockEn,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWdata, regRdata,
  input wire logic [6:0]  pinIn, pinOut, pinOe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  wire [6:0] f  = regWdata[22:16];
  wire [1:0] ck = {engineClockEn, pinClockEn};
  AST_SET: assert property (regWr && regAddr == 8'h30 |=> (pinOut & $past(f)) == $past(f))
    else $error("set level");
  AST_ODE: assert property (regWr && regAddr == 8'h40 |=> (pinOe & pinOut & $past(f)) == 7'h00)
    else $error("open drain on");
  AST_ODD: assert property (regWr && regAddr == 8'h44 |=> (pinOe & $past(f)) == $past(f))
    else $error("open drain off");
  AST_CEN: assert property (regWr && regAddr == 8'h50 |=> (ck & $past(regWdata[1:0])) == $past(regWdata[1:0]))
    else $error("clock on");
  AST_CDIS: assert property (regWr && regAddr == 8'h54 |=> (ck & $past(regWdata[1:0])) == 2'h0)
    else $error("clock off");
  AST_ODSR: assert property (regRd && regAddr == 8'h38 |=> regRdata == {9'h000, $past(pinOut), 16'h0000})
    else $error("level read");
  AST_PDSR: assert property (regRd && regAddr == 8'h3C |=> regRdata == {9'h000, $past(pinIn, 2), 16'h0000})
    else $error("pin level read");
  AST_PMSR: assert property (regRd && regAddr == 8'h58 |=> regRdata == {30'h0, $past(ck)})
    else $error("power read");
  AST_SRST: assert property (regWr && regAddr == 8'h60 && regWdata[0] |=> $stable(ck) && pinOut == 7'h00)
    else $error("soft reset");
  cover property (regWr && regAddr == 8'h60);
  cover property (regRd && regAddr == 8'h3C);
  cover property (ck == 2'h3);
endmodule : pin_io_bank_properties

// ==== tb/pin_line_model.sv ====
// far-side lines: pull-ups, with an outside device holding some lines low
`timescale 1ns/1ps
module pin_line_model (
  input wire logic [6:0] pinOut, pinOe, extLow,
  output logic     [6:0] pinIn
);
  assign pinIn = (pinOe & pinOut) | ~(pinOe | extLow);
endmodule : pin_line_model

// ==== tb/serial_port_pin_io_and_clock_gate_test.sv ====
// bench for the pin bank
`timescale 1ns/1ps
module serial_port_pin_io_and_clock_gate_test;
  logic mclk = 0, rst_b = 0, regWr = 0, regRd = 0, pinClockEn, engineClockEn;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0, regRdata;
  logic [6:0] pinIn, pinOut, pinOe;
  int num_errors = 0, compares = 0;
  pin_io_bank dut (.mclk, .rst_b, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .pinIn,
    .pinOut, .pinOe, .pinClockEn, .engineClockEn);
  pin_line_model lines (.pinOut, .pinOe, .extLow(7'h02), .pinIn);
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge mclk) regWr <= 1'h1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk) regWr <= 1'h0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge mclk) regRd <= 1'h1;
    regAddr <= a;
    @(posedge mclk) regRd <= 1'h0;
    #1 compares++;
    if (regRdata !== e) begin
      num_errors++;
      $display("unexpected reg %h expected %h seen %h", a, e, regRdata);
    end
  endtask : rd
  // compares a settled output against its expected value
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic pinLevels;
    wr(8'h30, 32'hFFFFFFFF);
    wr(8'h34, 32'h00050000);
    wr(8'h38, 32'h0);
    rd(8'h38, 32'h007A0000);
    rd(8'h3C, 32'h007A0000);
    chk("pinOut", 32'h7A, {25'h0, pinOut});
    chk("pinOe", 32'h7F, {25'h0, pinOe});
    wr(8'h40, 32'h00030000);
    rd(8'h48, 32'h00030000);
    chk("pinOe", 32'h7D, {25'h0, pinOe});
    rd(8'h3C, 32'h00780000);
    wr(8'h44, 32'hFF01FFFF);
    rd(8'h48, 32'h00020000);
  endtask : pinLevels
  task automatic clockGate;
    wr(8'h50, 32'h3);
    rd(8'h58, 32'h3);
    chk("clockEn", 32'h3, {30'h0, engineClockEn, pinClockEn});
    wr(8'h54, 32'hFFFFFFFD);
    rd(8'h58, 32'h2);
    wr(8'h60, 32'h1);
    rd(8'h58, 32'h2);
    rd(8'h48, 32'h0);
    rd(8'h38, 32'h0);
    chk("pinOut", 32'h0, {25'h0, pinOut});
    chk("pinOe", 32'h7F, {25'h0, pinOe});
    chk("clockEn", 32'h2, {30'h0, engineClockEn, pinClockEn});
    rd(8'hFC, 32'h0);
  endtask : clockGate
  task automatic finish_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  initial forever #5 mclk = ~mclk;
  initial begin
    repeat (10) @(posedge mclk);
    rst_b <= 1'h1;
    pinLevels();
    clockGate();
    finish_test();
  end
  // the tests need about 50 cycles
  initial begin
    #20000 num_errors++;
    finish_test();
  end
endmodule : serial_port_pin_io_and_clock_gate_test
bind pin_io_bank pin_io_bank_properties chk (.mclk, .rst_b, .regWr, .regRd, .pinClockEn,
  .engineClockEn, .regAddr, .regWdata, .regRdata, .pinIn, .pinOut, .pinOe);
